// ---- src/bku_consts.svh ----
// Constants of the breakpoint and instruction tag unit.
`ifndef BKU_CONSTS_SVH
`define BKU_CONSTS_SVH

// Register byte offsets within the slave window.
`define BKU_OFS_CTL0     8'h00
`define BKU_OFS_CTL1     8'h04
`define BKU_OFS_ADDR_HI  8'h08
`define BKU_OFS_ADDR_LO  8'h0C
`define BKU_OFS_CMP_HI   8'h10
`define BKU_OFS_CMP_LO   8'h14
`define BKU_OFS_STATUS   8'h18

// Fields of break_control_0.
`define BKU_C0_MODE_HI   7
`define BKU_C0_MODE_LO   6
`define BKU_C0_PROG      5
`define BKU_C0_ALE1      1
`define BKU_C0_ALE0      0

// Fields of break_control_1.
`define BKU_C1_DBE       6
`define BKU_C1_MBH       5
`define BKU_C1_MBL       4
`define BKU_C1_RWE1      3
`define BKU_C1_RW1       2
`define BKU_C1_RWE0      1
`define BKU_C1_RW0       0

// Fields of the status and command register.
`define BKU_ST_BDM       0
`define BKU_ST_TAG       1
`define BKU_CMD_TAG_GO   0

// Mode field codes.
`define BKU_MODE_OFF     2'h0
`define BKU_MODE_SWI     2'h1
`define BKU_MODE_FULL    2'h2
`define BKU_MODE_DUAL    2'h3

// Reset values.
`define BKU_CTL_RST      8'h00
`define BKU_CMP_RST      8'h00

// E clock period in system clock cycles, and instruction queue depth.
`define BKU_E_DIV        8
`define BKU_Q_DEPTH      2

`endif

// ---- src/bku_pkg.sv ----
// Types shared by the breakpoint and instruction tag unit.
package bku_pkg;

   typedef struct packed {
      logic        valid;
      logic        fetch;
      logic        rw;
      logic [15:0] addr;
      logic [15:0] data;
   } bku_bus_t;

   typedef struct packed {
      logic bp_hi;
      logic bp_lo;
      logic ext_hi;
      logic ext_lo;
   } bku_qtag_t;

endpackage

// ---- src/bku_cmp.sv ----
// One 16-bit breakpoint comparator with byte ignores and direction check.
`timescale 1ns/10ps
module bku_cmp (
   // Compared value and reference
   input  wire logic [15:0] value,
   input  wire logic [15:0] ref_val,
   // Qualifiers
   input  wire logic        ign_hi,
   input  wire logic        ign_lo,
   input  wire logic        rw_en,
   input  wire logic        rw_val,
   input  wire logic        rw,
   // Result
   output      logic        match
);
   always_comb begin
      match = (ign_hi | (value[15:8] == ref_val[15:8])) &
              (ign_lo | (value[7:0] == ref_val[7:0])) &
              (~rw_en | (rw == rw_val));
   end
endmodule

// ---- src/bku_tagq.sv ----
// Tag shadow of the instruction queue; tags advance with their words.
`timescale 1ns/10ps
`include "bku_consts.svh"
module bku_tagq import bku_pkg::*; #(
   parameter int DEPTH = `BKU_Q_DEPTH
) (
   // Clock and reset
   input  wire logic      clk,
   input  wire logic      rst,
   // Queue control
   input  wire logic      flush,
   input  wire logic      push,
   input  wire bku_qtag_t push_tags,
   input  wire logic      pop,
   // Head of queue
   output      bku_qtag_t head_tags
);
   localparam int CW = $clog2(DEPTH + 1);

   bku_qtag_t         slot_reg [DEPTH];
   bku_qtag_t         slot_next[DEPTH];
   logic [CW-1:0]     cnt_reg;
   logic [CW-1:0]     cnt_next;
   logic [CW-1:0]     base;
   logic              do_pop;

   always_comb begin
      do_pop = pop & (cnt_reg != '0);
      base = do_pop ? cnt_reg - 1'b1 : cnt_reg;
      for (int i = 0; i < DEPTH; i++) begin
         if (do_pop && i < DEPTH - 1) begin
            slot_next[i] = slot_reg[i+1];
         end else begin
            slot_next[i] = slot_reg[i];
         end
         if (push && base == CW'(i)) begin
            slot_next[i] = push_tags;
         end
      end
      cnt_next = base;
      if (push && base != CW'(DEPTH)) begin
         cnt_next = base + 1'b1;
      end
      // A flush discards words fetched but never executed, and their tags.
      if (flush) begin
         cnt_next = '0;
         for (int i = 0; i < DEPTH; i++) begin
            slot_next[i] = '0;
         end
      end
      head_tags = (cnt_reg != '0) ? slot_reg[0] : '0;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            slot_reg[i] <= '0;
         end
      end else begin
         cnt_reg <= cnt_next;
         for (int i = 0; i < DEPTH; i++) begin
            slot_reg[i] <= slot_next[i];
         end
      end
   end
endmodule

// ---- src/bku_top.sv ----
// Breakpoint comparators, instruction tag capture and AHB-Lite registers.
`timescale 1ns/10ps
`include "bku_consts.svh"
// Contract
// - Mode field picks off, dual SOFTWARE_INTERRUPT, full debug, or dual debug.
// - Second pair compares data in full mode, address in dual modes.
// - Direction qualifies matches only in the two debug-entry modes.
// - Program-only clear: a match breaks at the next instruction boundary.
// - Program-only set: tag the fetch, break only when it executes.
// - SOFTWARE_INTERRUPT dual mode ignores program-only and always breaks through tags.
// - Breakpoint 0 compares upper byte, or full address with enable 0.
// - Breakpoint 1 uses low-address enable 1 only in dual mode.
// - Second-register enable clear removes the second pair from compares.
// - High-byte mask ignores data bits 15:8 in full mode.
// - Low-byte mask ignores data bits 7-0 in full mode.
// - Breakpoint 1 direction check with enable 1 and value 1.
// - Breakpoint 0 direction check with enable 0 and value 0.
// - Direction enables have no effect in program breakpoints.
// - Comparison registers clear only at power-on; controls always RW.
// - Tag pins sampled at E fall; low level tags its byte.
// - Low tag pin carries strobe a quarter E cycle either side of E rise.
// - Tags travel with queue; tagged head enters debug mode.
// - Tag-and-go enables tagging; debug entry disables it.
// - Tagging is permitted in every operating mode of the chip.
// - No breakpoint matches while background debug mode is active.
// - In dual modes second-register enable enables breakpoint 1.
module bku_top import bku_pkg::*; #(
   parameter int E_DIV   = `BKU_E_DIV,
   parameter int Q_DEPTH = `BKU_Q_DEPTH
) (
   // Clock and resets
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        por,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic        hreadyout,
   output      logic        hresp,
   output      logic [31:0] hrdata,
   // CPU bus and instruction queue
   input  wire bku_bus_t    cpu_bus,
   input  wire logic        cpu_q_adv,
   input  wire logic        cpu_head_lo,
   input  wire logic        cpu_q_flush,
   input  wire logic        background_debug_mode,
   input  wire logic        cpu_low_byte_strobe,
   // Requests to the CPU
   output      logic        software_interrupt,
   output      logic        bdm_entry_req,
   output      logic        serial_cmd_allow,
   // Tag pins and E clock
   input  wire logic        high_tag_pin_n,
   input  wire logic        low_tag_pin_in,
   output      logic        low_tag_pin_out,
   output      logic        low_tag_pin_oe,
   output      logic        e_clock
);
   localparam int CW = $clog2(E_DIV);
   localparam int EH = E_DIV / 2;
   localparam int EQ = (E_DIV / 4 < 1) ? 1 : E_DIV / 4;

   // Bus slave state.
   logic        wr_pend_reg;
   logic        wr_pend_next;
   logic [7:0]  wr_addr_reg;
   logic [7:0]  wr_addr_next;
   logic [31:0] hrdata_reg;
   logic [31:0] hrdata_next;
   logic        acc;
   logic        tag_go_wr;

   // Register file.
   logic [7:0]  ctl0_reg;
   logic [7:0]  ctl0_next;
   logic [7:0]  ctl1_reg;
   logic [7:0]  ctl1_next;
   logic [7:0]  ah_reg;
   logic [7:0]  ah_next;
   logic [7:0]  al_reg;
   logic [7:0]  al_next;
   logic [7:0]  dh_reg;
   logic [7:0]  dh_next;
   logic [7:0]  dl_reg;
   logic [7:0]  dl_next;
   logic        tag_en_reg;
   logic        tag_en_next;
   logic        bdm_d_reg;

   // E clock divider and strobe window.
   logic [CW-1:0] ediv_reg;
   logic [CW-1:0] ediv_next;
   logic          e_clk_reg;
   logic          e_clk_next;
   logic          e_fall_en;
   logic          win_next;
   logic          oe_reg;
   logic          oe_next;
   logic          strb_reg;

   // Tag pin synchronisers and E fall capture.
   logic        hi_s1_reg;
   logic        hi_s2_reg;
   logic        lo_s1_reg;
   logic        lo_s2_reg;
   logic        cap_hi_reg;
   logic        cap_hi_next;
   logic        cap_lo_reg;
   logic        cap_lo_next;

   // Breakpoint decode.
   logic [1:0]  mode;
   logic        is_off;
   logic        is_swi;
   logic        is_full;
   logic        is_dual;
   logic        prog_bp;
   logic        rw_ok;
   logic        dbe;
   logic [15:0] cmp1_value;
   logic        cmp1_ign_hi;
   logic        cmp1_ign_lo;
   logic        m0;
   logic        m1;
   logic        hit;
   bku_qtag_t   push_tags;
   bku_qtag_t   head_tags;
   logic        head_ext;
   logic        head_bp;
   logic        swi_next;
   logic        swi_reg;
   logic        bdm_next;
   logic        bdm_reg;

   // ---------------- AHB-Lite slave and registers ----------------
   always_comb begin
      acc = hsel & htrans[1] & hready;
      wr_pend_next = acc & hwrite;
      wr_addr_next = acc ? haddr[7:0] : wr_addr_reg;
      ctl0_next = ctl0_reg;
      ctl1_next = ctl1_reg;
      ah_next = ah_reg;
      al_next = al_reg;
      dh_next = dh_reg;
      dl_next = dl_reg;
      tag_go_wr = 1'b0;
      if (wr_pend_reg) begin
         case (wr_addr_reg)
            `BKU_OFS_CTL0:    ctl0_next = hwdata[7:0];
            `BKU_OFS_CTL1:    ctl1_next = hwdata[7:0];
            `BKU_OFS_ADDR_HI: ah_next = hwdata[7:0];
            `BKU_OFS_ADDR_LO: al_next = hwdata[7:0];
            `BKU_OFS_CMP_HI:  dh_next = hwdata[7:0];
            `BKU_OFS_CMP_LO:  dl_next = hwdata[7:0];
            `BKU_OFS_STATUS:  tag_go_wr = hwdata[`BKU_CMD_TAG_GO];
            default:          tag_go_wr = 1'b0;
         endcase
      end
      // The command sets tagging and wins over a debug entry in the
      // same cycle; tagging is not gated by the chip's operating mode.
      tag_en_next = tag_go_wr |
                    (tag_en_reg & ~(background_debug_mode & ~bdm_d_reg));
      // Reads see the values after a write in the previous data phase,
      // so a write followed at once by a read of it is never stale.
      hrdata_next = 32'h0000_0000;
      if (acc && !hwrite) begin
         case (haddr[7:0])
            `BKU_OFS_CTL0:    hrdata_next[7:0] = ctl0_next;
            `BKU_OFS_CTL1:    hrdata_next[7:0] = ctl1_next;
            `BKU_OFS_ADDR_HI: hrdata_next[7:0] = ah_next;
            `BKU_OFS_ADDR_LO: hrdata_next[7:0] = al_next;
            `BKU_OFS_CMP_HI:  hrdata_next[7:0] = dh_next;
            `BKU_OFS_CMP_LO:  hrdata_next[7:0] = dl_next;
            `BKU_OFS_STATUS: begin
               hrdata_next[`BKU_ST_BDM] = background_debug_mode;
               hrdata_next[`BKU_ST_TAG] = tag_en_next;
            end
            default:          hrdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst || por) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg <= 32'h0000_0000;
         ctl0_reg <= `BKU_CTL_RST;
         ctl1_reg <= `BKU_CTL_RST;
         tag_en_reg <= 1'b0;
         bdm_d_reg <= 1'b0;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         hrdata_reg <= hrdata_next;
         ctl0_reg <= ctl0_next;
         ctl1_reg <= ctl1_next;
         tag_en_reg <= tag_en_next;
         bdm_d_reg <= background_debug_mode;
      end
      // Comparison registers survive ordinary resets.
      if (por) begin
         ah_reg <= `BKU_CMP_RST;
         al_reg <= `BKU_CMP_RST;
         dh_reg <= `BKU_CMP_RST;
         dl_reg <= `BKU_CMP_RST;
      end else begin
         ah_reg <= ah_next;
         al_reg <= al_next;
         dh_reg <= dh_next;
         dl_reg <= dl_next;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign serial_cmd_allow = ~tag_en_reg;

   // ---------------- E clock and tag pins ----------------
   always_comb begin
      ediv_next = (ediv_reg == CW'(E_DIV - 1)) ? '0 : ediv_reg + 1'b1;
      e_clk_next = ediv_next >= CW'(EH);
      // The synchronisers lag the pins by two cycles: this reads the samples
      // taken at the E fall, when the strobe has released the shared pin.
      e_fall_en = ediv_reg == CW'(1);
      win_next = (ediv_next >= CW'(EH - EQ)) && (ediv_next < CW'(EH + EQ));
      // Outside tagging the pin is a plain strobe output.
      oe_next = ~tag_en_reg | win_next;
      cap_hi_next = cap_hi_reg;
      cap_lo_next = cap_lo_reg;
      if (e_fall_en) begin
         cap_hi_next = tag_en_reg & ~hi_s2_reg;
         cap_lo_next = tag_en_reg & ~lo_s2_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || por) begin
         ediv_reg <= '0;
         e_clk_reg <= 1'b0;
         oe_reg <= 1'b1;
         strb_reg <= 1'b0;
         hi_s1_reg <= 1'b1;
         hi_s2_reg <= 1'b1;
         lo_s1_reg <= 1'b1;
         lo_s2_reg <= 1'b1;
         cap_hi_reg <= 1'b0;
         cap_lo_reg <= 1'b0;
      end else begin
         ediv_reg <= ediv_next;
         e_clk_reg <= e_clk_next;
         oe_reg <= oe_next;
         strb_reg <= cpu_low_byte_strobe;
         hi_s1_reg <= high_tag_pin_n;
         hi_s2_reg <= hi_s1_reg;
         lo_s1_reg <= low_tag_pin_in;
         lo_s2_reg <= lo_s1_reg;
         cap_hi_reg <= cap_hi_next;
         cap_lo_reg <= cap_lo_next;
      end
   end

   assign e_clock = e_clk_reg;
   assign low_tag_pin_out = strb_reg;
   assign low_tag_pin_oe = oe_reg;

   // ---------------- Breakpoint comparison ----------------
   always_comb begin
      mode = {ctl0_reg[`BKU_C0_MODE_HI], ctl0_reg[`BKU_C0_MODE_LO]};
      is_off = mode == `BKU_MODE_OFF;
      is_swi = mode == `BKU_MODE_SWI;
      is_full = mode == `BKU_MODE_FULL;
      is_dual = (mode == `BKU_MODE_DUAL) | is_swi;
      prog_bp = is_swi | (ctl0_reg[`BKU_C0_PROG] & ~is_off);
      rw_ok = ~is_swi & ~prog_bp;
      dbe = ctl1_reg[`BKU_C1_DBE];
      cmp1_value = is_full ? cpu_bus.data : cpu_bus.addr;
      cmp1_ign_hi = is_full & ctl1_reg[`BKU_C1_MBH];
      cmp1_ign_lo = is_full ? ctl1_reg[`BKU_C1_MBL]
                            : ~ctl0_reg[`BKU_C0_ALE1];
   end

   bku_cmp u_cmp0 (
      .value   (cpu_bus.addr),
      .ref_val ({ah_reg, al_reg}),
      .ign_hi  (1'b0),
      .ign_lo  (~ctl0_reg[`BKU_C0_ALE0]),
      .rw_en   (ctl1_reg[`BKU_C1_RWE0] & rw_ok),
      .rw_val  (ctl1_reg[`BKU_C1_RW0]),
      .rw      (cpu_bus.rw),
      .match   (m0)
   );

   bku_cmp u_cmp1 (
      .value   (cmp1_value),
      .ref_val ({dh_reg, dl_reg}),
      .ign_hi  (cmp1_ign_hi),
      .ign_lo  (cmp1_ign_lo),
      .rw_en   (is_dual & ctl1_reg[`BKU_C1_RWE1] & rw_ok),
      .rw_val  (ctl1_reg[`BKU_C1_RW1]),
      .rw      (cpu_bus.rw),
      .match   (m1)
   );

   always_comb begin
      hit = 1'b0;
      if (cpu_bus.valid && !background_debug_mode && !is_off) begin
         if (is_full) begin
            // Data compare has no meaning for program breakpoints.
            hit = m0 & (~dbe | ctl0_reg[`BKU_C0_PROG] | m1);
         end else begin
            hit = m0 | (dbe & m1);
         end
      end
      // Breakpoint tags ride on the high byte of the fetched word.
      push_tags = '{bp_hi: hit & prog_bp & cpu_bus.fetch,
                    bp_lo: 1'b0, ext_hi: cap_hi_reg, ext_lo: cap_lo_reg};
      head_ext = cpu_head_lo ? head_tags.ext_lo : head_tags.ext_hi;
      head_bp = cpu_head_lo ? head_tags.bp_lo : head_tags.bp_hi;
      swi_next = 1'b0;
      bdm_next = 1'b0;
      if (hit && !prog_bp) begin
         bdm_next = 1'b1;
      end
      if (cpu_q_adv && !background_debug_mode) begin
         if (head_ext) begin
            bdm_next = 1'b1;
         end
         if (head_bp) begin
            swi_next = is_swi;
            bdm_next = bdm_next | ~is_swi;
         end
      end
   end

   bku_tagq #(
      .DEPTH (Q_DEPTH)
   ) u_tagq (
      .clk       (clk),
      .rst       (rst | por),
      .flush     (cpu_q_flush),
      .push      (cpu_bus.valid & cpu_bus.fetch),
      .push_tags (push_tags),
      .pop       (cpu_q_adv),
      .head_tags (head_tags)
   );

   always_ff @(posedge clk) begin
      if (rst || por) begin
         swi_reg <= 1'b0;
         bdm_reg <= 1'b0;
      end else begin
         swi_reg <= swi_next;
         bdm_reg <= bdm_next;
      end
   end

   assign software_interrupt = swi_reg;
   assign bdm_entry_req = bdm_reg;
endmodule

// ---- tb/bku_chk_asserts.sv ----
// Concurrent checks on the ports of the breakpoint and tag unit.
`timescale 1ns/10ps
module bku_chk import bku_pkg::*; #(
   parameter int E_DIV = 8
) (
   // Clock and resets
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        por,
   // Register bus
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   // CPU side
   input wire bku_bus_t    cpu_bus,
   input wire logic        cpu_q_adv,
   input wire logic        background_debug_mode,
   input wire logic        software_interrupt,
   input wire logic        bdm_entry_req,
   input wire logic        serial_cmd_allow,
   // Tag pin and E clock
   input wire logic        low_tag_pin_oe,
   input wire logic        e_clock
);
   localparam int EH = E_DIV / 2;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || por);

   // The strobe holds the shared pin on both sides of the E rise.
   sequence strobe_span;
      low_tag_pin_oe ##1 low_tag_pin_oe;
   endsequence

   rd_idle_a: assert property (
      !$past(hsel && htrans[1] && !hwrite && hready) |-> hrdata == 32'h0)
      else $error("read data present outside a read");
   req_cause_a: assert property (
      bdm_entry_req |-> $past(cpu_bus.valid || cpu_q_adv))
      else $error("debug request without a bus cycle or queue advance");
   swi_tagged_a: assert property (
      software_interrupt |-> $past(cpu_q_adv))
      else $error("software interrupt not from an executed opcode");
   dbg_quiet_a: assert property (
      $past(background_debug_mode) |-> !software_interrupt && !bdm_entry_req)
      else $error("request while debug mode active");
   one_kind_a: assert property (
      !(software_interrupt && bdm_entry_req))
      else $error("both request kinds at once");
   strobe_win_a: assert property (
      $rose(e_clock) |-> $past(low_tag_pin_oe) ##0 strobe_span)
      else $error("strobe not driven around E rise");
   e_clock_period_a: assert property (
      $rose(e_clock) |-> ##EH $fell(e_clock) ##EH $rose(e_clock))
      else $error("E clock period wrong");
   untag_a: assert property (
      $rose(background_debug_mode) && !hsel && !$past(hsel)
      |-> ##[1:3] serial_cmd_allow)
      else $error("tagging not dropped on debug entry");
endmodule

bind bku_top bku_chk #(.E_DIV(E_DIV)) chk_i (
   .clk(clk), .rst(rst), .por(por), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .cpu_bus(cpu_bus),
   .cpu_q_adv(cpu_q_adv), .background_debug_mode(background_debug_mode),
   .software_interrupt(software_interrupt), .bdm_entry_req(bdm_entry_req),
   .serial_cmd_allow(serial_cmd_allow), .low_tag_pin_oe(low_tag_pin_oe),
   .e_clock(e_clock)
);

// ---- tb/bku_tool.sv ----
// Debug tool model that drives the two tag pins of the unit.
`timescale 1ns/10ps
module bku_tool (
   // Tag requests from the bench
   input  wire logic hi_req,
   input  wire logic lo_req,
   // Shared low pin as the device drives it
   input  wire logic low_tag_pin_oe,
   input  wire logic low_tag_pin_out,
   // Resolved pin levels
   output      logic high_tag_pin_n,
   output      logic low_tag_pin_in
);
   // Both pins have pull-ups, so a released pin reads high.
   assign high_tag_pin_n = !hi_req;
   // The tool stays off the shared pin while the strobe is driven.
   assign low_tag_pin_in = low_tag_pin_oe ? low_tag_pin_out
                                          : !lo_req;
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the breakpoint and instruction tag unit.
`timescale 1ns/10ps
`include "bku_consts.svh"
module tb_top import bku_pkg::*;;
   logic        clk = 1'h0, rst = 1'h1, por = 1'h1, hsel = 1'h0;
   logic        hwrite = 1'h0, hreadyout, hresp, hi_req = 1'h0;
   logic        lo_req = 1'h0, cpu_q_adv = 1'h0, cpu_head_lo = 1'h0;
   logic        cpu_q_flush = 1'h0, background_debug_mode = 1'h0;
   logic        software_interrupt, bdm_entry_req, serial_cmd_allow;
   logic        high_tag_pin_n, low_tag_pin_in, low_tag_pin_out;
   logic        low_tag_pin_oe, e_clock;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
   logic [1:0]  htrans = 2'h0, rq;
   bku_bus_t    cpu_bus = 35'h0;
   int          bad_count = 0, n_checks = 0, cycles = 0;

   bku_top dut (
      .clk(clk), .rst(rst), .por(por), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .cpu_bus(cpu_bus), .cpu_q_adv(cpu_q_adv),
      .cpu_head_lo(cpu_head_lo), .cpu_q_flush(cpu_q_flush),
      .background_debug_mode(background_debug_mode),
      .cpu_low_byte_strobe(1'h1), .software_interrupt(software_interrupt),
      .bdm_entry_req(bdm_entry_req), .serial_cmd_allow(serial_cmd_allow),
      .high_tag_pin_n(high_tag_pin_n), .low_tag_pin_in(low_tag_pin_in),
      .low_tag_pin_out(low_tag_pin_out), .low_tag_pin_oe(low_tag_pin_oe),
      .e_clock(e_clock)
   );
   bku_tool tool (
      .hi_req(hi_req), .lo_req(lo_req), .low_tag_pin_oe(low_tag_pin_oe),
      .low_tag_pin_out(low_tag_pin_out), .high_tag_pin_n(high_tag_pin_n),
      .low_tag_pin_in(low_tag_pin_in)
   );

   initial begin
      forever #2.5 clk = ~clk;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // The whole run needs well under a thousand cycles.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rdy;
      @(posedge clk);
      while (hreadyout !== 1'h1) begin
         @(posedge clk);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      rdy();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      v = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk(v, e);
   endtask

   // One CPU cycle; the request lands one cycle after it is taken.
   task automatic cq(input logic [34:0] b, input logic [2:0] q,
                     input logic [1:0] e);
      @(posedge clk);
      cpu_bus <= b;
      {cpu_q_adv, cpu_q_flush, cpu_head_lo} <= q;
      @(posedge clk);
      cpu_bus <= 35'h0;
      cpu_q_adv <= 1'h0;
      cpu_q_flush <= 1'h0;
      #1 rq = {software_interrupt, bdm_entry_req};
      chk({30'h0, rq}, {30'h0, e});
   endtask

   task automatic rc(input logic [7:0] c0, c1, input logic [15:0] a, d,
                     input logic rw, dm, input logic [1:0] e);
      bus(1'h1, `BKU_OFS_CTL0, {24'h0, c0});
      bus(1'h1, `BKU_OFS_CTL1, {24'h0, c1});
      @(posedge clk);
      background_debug_mode <= dm;
      cq({2'h2, rw, a, d}, 3'h0, e);
      background_debug_mode <= 1'h0;
   endtask

   // Hold the tags over a whole E period so the synchroniser sees them.
   task automatic ext(input logic h, l, hl, input logic [1:0] e);
      @(posedge clk);
      hi_req <= h;
      lo_req <= l;
      @(negedge e_clock);
      @(negedge e_clock);
      @(posedge clk);
      hi_req <= 1'h0;
      lo_req <= 1'h0;
      cq({3'h7, 16'h5555, 16'h0}, 3'h0, 2'h0);
      cq(35'h0, {2'h2, hl}, e);
      chk({31'h0, low_tag_pin_out}, 32'h1);
   endtask

   task automatic pulse(input logic p);
      @(posedge clk);
      rst <= !p;
      por <= p;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      por <= 1'h0;
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      por <= 1'h0;
      rchk(`BKU_OFS_CTL1, 32'h0);
      bus(1'h1, `BKU_OFS_CTL0, 32'hE3);
      rchk(`BKU_OFS_CTL0, 32'hE3);
      bus(1'h1, 8'h1C, 32'hFF);
      rchk(8'h1C, 32'h0);
      for (int i = 0; i < 4; i++) begin
         bus(1'h1, `BKU_OFS_ADDR_HI + 8'(4 * i), 32'hA5);
      end
      pulse(1'h0);
      rchk(`BKU_OFS_CTL0, 32'h0);
      for (int i = 0; i < 4; i++) begin
         rchk(`BKU_OFS_ADDR_HI + 8'(4 * i), 32'hA5);
      end
      pulse(1'h1);
      for (int i = 0; i < 4; i++) begin
         rchk(`BKU_OFS_ADDR_HI + 8'(4 * i), 32'h0);
         bus(1'h1, `BKU_OFS_ADDR_HI + 8'(4 * i),
             {24'h0, 8'(32'h1234ABCD >> (24 - 8 * i))});
      end
      rc(8'h00, 8'h40, 16'h1234, 16'hABCD, 1'h1, 1'h0, 2'h0);
      rc(8'h81, 8'h40, 16'h1234, 16'hABCD, 1'h1, 1'h0, 2'h1);
      rc(8'h81, 8'h40, 16'h1234, 16'hAB00, 1'h1, 1'h0, 2'h0);
      rc(8'h81, 8'h50, 16'h1234, 16'hAB00, 1'h1, 1'h0, 2'h1);
      rc(8'h81, 8'h60, 16'h1234, 16'h00CD, 1'h1, 1'h0, 2'h1);
      rc(8'h81, 8'h00, 16'h1234, 16'h0000, 1'h1, 1'h0, 2'h1);
      rc(8'h80, 8'h00, 16'h12FF, 16'h0000, 1'h1, 1'h0, 2'h1);
      rc(8'h81, 8'h00, 16'h12FF, 16'h0000, 1'h1, 1'h0, 2'h0);
      rc(8'h81, 8'h02, 16'h1234, 16'h0000, 1'h1, 1'h0, 2'h0);
      rc(8'h81, 8'h03, 16'h1234, 16'h0000, 1'h1, 1'h0, 2'h1);
      rc(8'hC1, 8'h40, 16'hABFF, 16'h0000, 1'h1, 1'h0, 2'h1);
      rc(8'hC3, 8'h40, 16'hABFF, 16'h0000, 1'h1, 1'h0, 2'h0);
      rc(8'hC1, 8'h00, 16'hABCD, 16'h0000, 1'h1, 1'h0, 2'h0);
      rc(8'hC3, 8'h4C, 16'hABCD, 16'h0000, 1'h0, 1'h0, 2'h0);
      rc(8'hC3, 8'h4C, 16'hABCD, 16'h0000, 1'h1, 1'h0, 2'h1);
      rc(8'h83, 8'h48, 16'h1234, 16'hABCD, 1'h1, 1'h0, 2'h1);
      rc(8'h81, 8'h40, 16'h1234, 16'hABCD, 1'h1, 1'h1, 2'h0);
      rc(8'h41, 8'h40, 16'h1234, 16'h0000, 1'h1, 1'h0, 2'h0);
      rc(8'hE1, 8'h40, 16'h1234, 16'h0000, 1'h1, 1'h0, 2'h0);
      bus(1'h1, `BKU_OFS_CTL0, 32'h41);
      bus(1'h1, `BKU_OFS_CTL1, 32'h42);
      cq({3'h7, 16'h1234, 16'h0}, 3'h0, 2'h0);
      cq(35'h0, 3'h4, 2'h2);
      cq({3'h7, 16'h1234, 16'h0}, 3'h0, 2'h0);
      cq(35'h0, 3'h2, 2'h0);
      cq({3'h7, 16'h0000, 16'h0}, 3'h0, 2'h0);
      cq(35'h0, 3'h4, 2'h0);
      bus(1'h1, `BKU_OFS_CTL0, 32'hE1);
      bus(1'h1, `BKU_OFS_CTL1, 32'h40);
      cq({3'h7, 16'hABCD, 16'h0}, 3'h0, 2'h0);
      cq(35'h0, 3'h4, 2'h1);
      bus(1'h1, `BKU_OFS_CTL0, 32'h0);
      bus(1'h1, `BKU_OFS_STATUS, 32'h1);
      rchk(`BKU_OFS_STATUS, 32'h2);
      chk({31'h0, serial_cmd_allow}, 32'h0);
      ext(1'h1, 1'h0, 1'h1, 2'h0);
      ext(1'h1, 1'h0, 1'h0, 2'h1);
      ext(1'h0, 1'h1, 1'h1, 2'h1);
      ext(1'h0, 1'h1, 1'h0, 2'h0);
      @(posedge clk);
      background_debug_mode <= 1'h1;
      rchk(`BKU_OFS_STATUS, 32'h1);
      chk({31'h0, serial_cmd_allow}, 32'h1);
      background_debug_mode <= 1'h0;
      repeat (4) @(posedge clk);
      conclude();
   end
endmodule
